// >>> hw/scmg_pkg.sv
// Contract
// RQ1 - Line low 200 ms enters command mode
// RQ2 - Three trigger characters, gaps under 80 ms
// RQ3 - Gaps over 120 ms mean plain data
// RQ4 - Host avoids gaps between 80 and 120 ms
// RQ5 - Only the configured trigger method counts
// RQ6 - Entry sends less-than, E, carriage return
// RQ7 - Entry closes every open TCP connection
// RQ8 - No new TCP connections in command mode
// RQ9 - No UDP data in command mode
// RQ10 - Restart command saves or discards changes
// RQ11 - Five idle minutes restart, discarding changes
// RQ12 - Changes stay volatile until explicitly saved
// RQ13 - Carriage return ends command, always answered
// RQ14 - Probe answers E, error answers 3
// RQ15 - Report data mode or command mode
// RQ16 - Host avoids very slow baud rates
// RQ17 - Line trigger by default, never both
// RQ18 - Recognised trigger characters are not forwarded
`default_nettype none
package scmg_pkg;

  // Trigger methods; the fourth code selects nothing.
  typedef enum logic [1:0] {TRIG_OFF, TRIG_LINE, TRIG_CHAR, TRIG_NONE} scmg_trig_e;

  localparam int BYTE_W = 8;
  localparam int TRIG_LEN = 3;
  localparam scmg_trig_e TRIG_RESET = TRIG_LINE;
  localparam logic [7:0] TRIG_CHAR_RESET = 8'h2B;

  // Reply and line characters.
  localparam logic [7:0] CH_LT = 8'h3C;
  localparam logic [7:0] CH_OK = 8'h45;
  localparam logic [7:0] CH_ERR = 8'h33;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;

  // Restart command: lead, write, two opcode letters, one argument.
  localparam logic [7:0] CMD_LEAD = 8'h3E;
  localparam logic [7:0] CMD_WRITE = 8'h57;
  localparam logic [7:0] RESTART_OPCODE0 = 8'h42;
  localparam logic [7:0] RESTART_OPCODE1 = 8'h52;
  localparam logic [7:0] ARG_DROP = 8'h31;
  localparam logic [7:0] ARG_SAVE = 8'h32;
  localparam logic [2:0] CMD_LEN = 3'h5;

  // Timing figures and the cycle counts derived from them at 200 MHz.
  localparam longint CLK_HZ = 200_000_000;
  localparam longint HOLD_MS = 200;
  localparam longint GAP_MS = 80;
  localparam longint IDLE_MIN = 5;
  localparam longint HOLD_CYC = (HOLD_MS * CLK_HZ + 999) / 1000;
  localparam longint GAP_CYC = (GAP_MS * CLK_HZ) / 1000;
  localparam longint IDLE_CYC = IDLE_MIN * 60 * CLK_HZ;
  localparam int HOLD_W = 26;
  localparam int GAP_W = 24;
  localparam int IDLE_W = 36;

  localparam int FIFO_DEPTH = 8;

endpackage
`default_nettype wire

// >>> hw/scmg_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module scmg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [0:DEPTH-1];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  // Full when the pointers differ only in the wrap bit.
  assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write.
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointer update.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // A pop never happens on an empty buffer.
  chk_fifo_no_underrun: assert property (@(posedge mclk) disable iff (rst)
    pop |-> (wr_q != rd_q)) else $error("fifo popped while empty");
endmodule
`default_nettype wire

// >>> hw/scmg_gate.sv
`timescale 1ns/1ps
`default_nettype none
module scmg_gate #(
  parameter logic [scmg_pkg::HOLD_W-1:0] HOLD_CYCLES = scmg_pkg::HOLD_W'(scmg_pkg::HOLD_CYC),
  parameter logic [scmg_pkg::GAP_W-1:0]  GAP_CYCLES  = scmg_pkg::GAP_W'(scmg_pkg::GAP_CYC),
  parameter logic [scmg_pkg::IDLE_W-1:0] IDLE_CYCLES = scmg_pkg::IDLE_W'(scmg_pkg::IDLE_CYC)
) (
  // Clock and reset.
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // Configuration, taken on cfg_load.
  input  wire logic                        cfg_load,
  input  wire scmg_pkg::scmg_trig_e        cfg_mode,
  input  wire logic [scmg_pkg::BYTE_W-1:0] cfg_char0,
  input  wire logic [scmg_pkg::BYTE_W-1:0] cfg_char1,
  input  wire logic [scmg_pkg::BYTE_W-1:0] cfg_char2,
  // Trigger line, low to request command mode.
  input  wire logic                        trigger_input_line_n,
  // Bytes received from the serial port.
  input  wire logic                        rx_valid,
  output logic                             rx_ready,
  input  wire logic [scmg_pkg::BYTE_W-1:0] rx_data,
  // Bytes sent on the serial port.
  output logic                             tx_valid_q,
  input  wire logic                        tx_ready,
  output logic      [scmg_pkg::BYTE_W-1:0] tx_data_q,
  // Payload toward the network.
  output logic                             net_valid_q,
  input  wire logic                        net_ready,
  output logic      [scmg_pkg::BYTE_W-1:0] net_data_q,
  // Mode and network control.
  output logic                             cmd_mode_q,
  output logic                             tcp_close_q,
  output logic                             tcp_block_q,
  output logic                             udp_block_q,
  output logic                             restart_save_q,
  output logic                             restart_drop_q
);
  import scmg_pkg::*;

  typedef enum {RP_IDLE, RP_LT, RP_CODE, RP_CR} scmg_reply_e;

  scmg_trig_e        mode_q;
  logic [7:0]        tchar_q [0:TRIG_LEN-1];
  logic [HOLD_W-1:0] hold_cnt_q;
  logic [GAP_W-1:0]  gap_cnt_q;
  logic [IDLE_W-1:0] idle_cnt_q;
  logic [1:0]        pend_q;
  logic              flush_q;
  logic [1:0]        flush_idx_q;
  scmg_reply_e       rp_q;
  logic [7:0]        code_q;
  logic [2:0]        len_q;
  logic              ok_q;
  logic [7:0]        arg_q;
  logic              hw_fire;
  logic              sw_match;
  logic              sw_fire;
  logic              enter;
  logic              flush_start;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic [7:0]        fifo_in_data;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [7:0]        fifo_out_data;
  logic              cmd_fire;
  logic              line_end;
  logic              line_probe;
  logic              line_restart;
  logic              line_valid;
  logic              idle_fire;
  logic [7:0]        expect_ch;

  // Configuration; reset selects the line method alone.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mode_q <= TRIG_RESET; // [RQ17]
      for (int i = 0; i < TRIG_LEN; i++)
      begin
        tchar_q[i] <= TRIG_CHAR_RESET;
      end
    end
    else if (cfg_load)
    begin
      mode_q     <= cfg_mode;
      tchar_q[0] <= cfg_char0;
      tchar_q[1] <= cfg_char1;
      tchar_q[2] <= cfg_char2;
    end
  end

  // Line method: count consecutive low cycles, fire on the last one needed.
  assign hw_fire = (mode_q == TRIG_LINE) && !cmd_mode_q && !trigger_input_line_n
                   && (hold_cnt_q == HOLD_CYCLES - 1'b1); // [RQ1] [RQ5]

  always_ff @(posedge mclk)
  begin
    if (rst || trigger_input_line_n || cmd_mode_q || (mode_q != TRIG_LINE))
    begin
      hold_cnt_q <= '0;
    end
    else if (hold_cnt_q != HOLD_CYCLES - 1'b1)
    begin
      hold_cnt_q <= hold_cnt_q + 1'b1; // [RQ1]
    end
  end

  // Character method: held-back candidates are matched in order.
  assign sw_match    = (mode_q == TRIG_CHAR) && !cmd_mode_q && !flush_q
                       && (rx_data == tchar_q[pend_q]); // [RQ5]
  assign sw_fire     = rx_valid && sw_match && (pend_q == 2'h2); // [RQ2]
  assign enter       = hw_fire || sw_fire;
  // A mismatch or an expired gap releases the candidates as data.
  assign flush_start = !cmd_mode_q && !flush_q && (pend_q != 2'h0)
                       && ((rx_valid && !sw_match) || (gap_cnt_q == GAP_CYCLES)); // [RQ3]

  // Receive acceptance; a mismatching byte waits until the flush is done.
  always_comb
  begin
    if (cmd_mode_q)
    begin
      rx_ready = (rp_q == RP_IDLE) && !tx_valid_q;
    end
    else
    begin
      rx_ready = !flush_q && (sw_match || ((pend_q == 2'h0) && fifo_in_ready));
    end
  end

  // Payload into the buffer: flushed candidates first, else the plain byte.
  assign fifo_in_valid = flush_q || (!cmd_mode_q && rx_valid && !sw_match && (pend_q == 2'h0));
  assign fifo_in_data  = flush_q ? tchar_q[flush_idx_q] : rx_data;

  // Candidate count, gap timer and flush walk.
  always_ff @(posedge mclk)
  begin
    if (rst || cmd_mode_q)
    begin
      pend_q      <= 2'h0;
      gap_cnt_q   <= '0;
      flush_q     <= 1'b0;
      flush_idx_q <= 2'h0;
    end
    else if (flush_q)
    begin
      gap_cnt_q <= '0;
      if (fifo_in_ready)
      begin
        flush_idx_q <= flush_idx_q + 1'b1;
        if (flush_idx_q == pend_q - 1'b1)
        begin
          flush_q <= 1'b0;
          pend_q  <= 2'h0;
        end
      end
    end
    else if (flush_start)
    begin
      flush_q     <= 1'b1;
      flush_idx_q <= 2'h0;
    end
    else if (rx_valid && sw_match)
    begin
      // Matched candidates are held back, never forwarded on success.
      pend_q    <= sw_fire ? 2'h0 : pend_q + 1'b1; // [RQ18]
      gap_cnt_q <= '0;
    end
    else if (pend_q != 2'h0)
    begin
      gap_cnt_q <= gap_cnt_q + 1'b1; // [RQ3]
    end
  end

  scmg_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // Network output stage; nothing new leaves while in command mode.
  assign fifo_out_ready = !cmd_mode_q && (!net_valid_q || net_ready); // [RQ9]

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      net_valid_q <= 1'b0;
      net_data_q  <= '0;
    end
    else if (fifo_out_ready)
    begin
      net_valid_q <= fifo_out_valid;
      net_data_q  <= fifo_out_data;
    end
    else if (net_ready)
    begin
      net_valid_q <= 1'b0;
    end
  end

  // Mode state and network suspension.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cmd_mode_q  <= 1'b0;
      tcp_close_q <= 1'b0;
      tcp_block_q <= 1'b0;
      udp_block_q <= 1'b0;
    end
    else
    begin
      cmd_mode_q  <= cmd_mode_q || enter; // [RQ15]
      tcp_close_q <= enter; // [RQ7]
      tcp_block_q <= cmd_mode_q || enter; // [RQ8]
      udp_block_q <= cmd_mode_q || enter; // [RQ9]
    end
  end

  // Command line parsing; an LF right after a terminator is skipped.
  assign cmd_fire     = cmd_mode_q && rx_valid && rx_ready;
  assign line_end     = cmd_fire && (rx_data == CH_CR); // [RQ13]
  assign line_probe   = (len_q == 3'h0); // [RQ14]
  assign line_restart = (len_q == CMD_LEN) && ok_q && ((arg_q == ARG_DROP) || (arg_q == ARG_SAVE));
  assign line_valid   = line_probe || line_restart;

  always_comb
  begin
    case (len_q)
      3'h0: expect_ch = CMD_LEAD;
      3'h1: expect_ch = CMD_WRITE;
      3'h2: expect_ch = RESTART_OPCODE0;
      3'h3: expect_ch = RESTART_OPCODE1;
      default: expect_ch = rx_data;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst || enter || line_end)
    begin
      len_q <= 3'h0;
      ok_q  <= 1'b1;
      arg_q <= 8'h00;
    end
    else if (cmd_fire && !((rx_data == CH_LF) && (len_q == 3'h0)))
    begin
      if (len_q != 3'h6)
      begin
        len_q <= len_q + 1'b1;
      end
      if (len_q == 3'h4)
      begin
        arg_q <= rx_data;
      end
      if (rx_data != expect_ch)
      begin
        ok_q <= 1'b0;
      end
    end
  end

  // Restart requests; only the save variant commits session changes.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      restart_save_q <= 1'b0;
      restart_drop_q <= 1'b0;
    end
    else
    begin
      restart_save_q <= line_end && line_restart && (arg_q == ARG_SAVE); // [RQ10] [RQ12]
      restart_drop_q <= (line_end && line_restart && (arg_q == ARG_DROP)) || idle_fire; // [RQ10] [RQ11]
    end
  end

  // Inactivity timer, restarted by every valid command; one in the last cycle wins.
  assign idle_fire = cmd_mode_q && !(line_end && line_valid)
                     && (idle_cnt_q == IDLE_CYCLES - 1'b1); // [RQ11]

  always_ff @(posedge mclk)
  begin
    if (rst || !cmd_mode_q || (line_end && line_valid) || idle_fire)
    begin
      idle_cnt_q <= '0;
    end
    else
    begin
      idle_cnt_q <= idle_cnt_q + 1'b1; // [RQ11]
    end
  end

  // Reply sender: less-than, code, carriage return.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rp_q       <= RP_IDLE;
      code_q     <= CH_OK;
      tx_valid_q <= 1'b0;
      tx_data_q  <= '0;
    end
    else
    begin
      case (rp_q)
        RP_IDLE:
        begin
          if (enter || line_end)
          begin
            rp_q       <= RP_LT;
            code_q     <= (enter || line_valid) ? CH_OK : CH_ERR; // [RQ6] [RQ14]
            tx_valid_q <= 1'b1;
            tx_data_q  <= CH_LT; // [RQ6] [RQ13]
          end
        end
        RP_LT:
        begin
          if (tx_ready)
          begin
            rp_q      <= RP_CODE;
            tx_data_q <= code_q;
          end
        end
        RP_CODE:
        begin
          if (tx_ready)
          begin
            rp_q      <= RP_CR;
            tx_data_q <= CH_CR;
          end
        end
        RP_CR:
        begin
          if (tx_ready)
          begin
            rp_q       <= RP_IDLE;
            tx_valid_q <= 1'b0;
          end
        end
        default:
        begin
          rp_q       <= RP_IDLE;
          tx_valid_q <= 1'b0;
        end
      endcase
    end
  end

  chk_line_hold_time: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
    ($rose(cmd_mode_q) && $past(mode_q) == TRIG_LINE) |-> $past(!trigger_input_line_n)
      && ($past(hold_cnt_q) == HOLD_CYCLES - 1'b1)) else $error("line entry too early");
  chk_char_trigger_run: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
    ($rose(cmd_mode_q) && $past(mode_q) == TRIG_CHAR) |-> $past(pend_q) == 2'h2)
    else $error("character entry without three matches");
  chk_gap_bound: assert property (@(posedge mclk) disable iff (rst) // [RQ3]
    (gap_cnt_q == GAP_CYCLES) && !cmd_mode_q && !flush_q |=> flush_q || cmd_mode_q)
    else $error("expired gap did not release candidates");
  chk_method_only: assert property (@(posedge mclk) disable iff (rst) // [RQ5]
    $rose(cmd_mode_q) |-> ($past(mode_q) == TRIG_LINE) || ($past(mode_q) == TRIG_CHAR))
    else $error("entry with no trigger method selected");
  chk_entry_reply: assert property (@(posedge mclk) disable iff (rst) // [RQ6]
    $rose(cmd_mode_q) |-> tx_valid_q && (tx_data_q == CH_LT) && (code_q == CH_OK))
    else $error("entry reply not started");
  chk_tcp_close: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
    $rose(cmd_mode_q) |-> tcp_close_q ##1 !tcp_close_q) else $error("tcp close not one pulse");
  chk_tcp_block: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
    tcp_block_q == cmd_mode_q) else $error("tcp block differs from mode");
  chk_udp_silent: assert property (@(posedge mclk) disable iff (rst) // [RQ9]
    (cmd_mode_q && !net_valid_q) |=> !net_valid_q && udp_block_q)
    else $error("payload left in command mode");
  chk_restart_variant: assert property (@(posedge mclk) disable iff (rst) // [RQ10]
    !(restart_save_q && restart_drop_q)) else $error("both restart variants at once");
  chk_idle_restart: assert property (@(posedge mclk) disable iff (rst) // [RQ11]
    idle_fire |=> restart_drop_q && !restart_save_q) else $error("idle restart missing");
  chk_cr_reply: assert property (@(posedge mclk) disable iff (rst) // [RQ13]
    line_end |=> tx_valid_q && (tx_data_q == CH_LT) ##[1:300] (tx_data_q == CH_CR))
    else $error("terminator not answered");
endmodule
`default_nettype wire

// >>> tb/scmg_host.sv
`timescale 1ns/1ps
`default_nettype none
module scmg_host (
  // Serial bytes toward the block.
  input  wire logic       mclk,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic      [7:0] rx_data,
  // Serial bytes from the block.
  input  wire logic       tx_valid_q,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data_q,
  // Pacing and hang report.
  input  wire logic       slow,
  output logic            stuck
);
  logic [7:0] reply[$];
  logic [1:0] pace_q;

  // Line idles with a pattern, not the last byte.
  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'hA5;
    tx_ready = 1'b0;
    pace_q   = 2'h0;
    stuck    = 1'b0;
  end

  // Takes reply bytes every cycle, or one cycle in three when slow.
  always @(posedge mclk)
  begin
    pace_q   <= (pace_q == 2'h2) ? 2'h0 : pace_q + 2'h1;
    tx_ready <= !slow || (pace_q == 2'h1);
    if (tx_valid_q && tx_ready)
      reply.push_back(tx_data_q);
  end

  // Holds one byte until the block takes it; bytes go back to back.
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    rx_valid <= 1'b1;
    rx_data  <= b;
    do
    begin
      @(posedge mclk);
      n++;
    end while (rx_ready !== 1'b1 && n < 200);
    if (n >= 200)
      stuck <= 1'b1;
  endtask

  // Releases the line and scrambles the data.
  task automatic rest();
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
endmodule
`default_nettype wire

// >>> tb/test_scmg_gate.sv
`timescale 1ns/1ps
`default_nettype none
module test_scmg_gate;
  import scmg_pkg::*;
  localparam logic [HOLD_W-1:0] HOLD = HOLD_W'(20);
  localparam logic [GAP_W-1:0]  GAP  = GAP_W'(10);
  localparam logic [IDLE_W-1:0] IDLE = IDLE_W'(200);
  logic       mclk, rst, cfg_load, line_n, rx_valid, rx_ready, tx_valid_q, tx_ready;
  logic       net_valid_q, net_ready, cmd_mode_q, tcp_close_q, tcp_block_q, udp_block_q;
  logic       restart_save_q, restart_drop_q, slow, stuck;
  logic [7:0] cfg_char0, cfg_char1, cfg_char2, rx_data, tx_data_q, net_data_q;
  scmg_trig_e cfg_mode;
  logic [7:0] netq[$];
  int         err_count, n_tests, n_close, n_drop, n_save;

  scmg_gate #(.HOLD_CYCLES(HOLD), .GAP_CYCLES(GAP), .IDLE_CYCLES(IDLE)) uut (
    .mclk(mclk), .rst(rst), .cfg_load(cfg_load), .cfg_mode(cfg_mode),
    .cfg_char0(cfg_char0), .cfg_char1(cfg_char1), .cfg_char2(cfg_char2),
    .trigger_input_line_n(line_n), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready), .tx_data_q(tx_data_q),
    .net_valid_q(net_valid_q), .net_ready(net_ready), .net_data_q(net_data_q),
    .cmd_mode_q(cmd_mode_q), .tcp_close_q(tcp_close_q), .tcp_block_q(tcp_block_q),
    .udp_block_q(udp_block_q), .restart_save_q(restart_save_q),
    .restart_drop_q(restart_drop_q));
  scmg_host host (
    .mclk(mclk), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .tx_valid_q(tx_valid_q), .tx_ready(tx_ready), .tx_data_q(tx_data_q),
    .slow(slow), .stuck(stuck));

  // Clock at 200 MHz.
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Records network bytes and counts the control pulses.
  always @(posedge mclk)
  begin
    if (net_valid_q && net_ready)
      netq.push_back(net_data_q);
    n_close += tcp_close_q;
    n_drop  += restart_drop_q;
    n_save  += restart_save_q;
  end

  // A hung handshake ends the run.
  always @(posedge stuck)
  begin
    err_count++;
    test_done();
  end

  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Resets for two cycles, then loads a trigger method if not the default.
  task automatic reset_dut(input scmg_trig_e mode);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst      <= 1'b0;
    cfg_load <= (mode != TRIG_LINE);
    cfg_mode <= mode;
    @(posedge mclk);
    cfg_load <= 1'b0;
    netq.delete();
    host.reply.delete();
    n_close = 0;
    n_drop  = 0;
    n_save  = 0;
  endtask

  // Sends bytes back to back, then releases the line.
  task automatic send_q(input logic [7:0] q[$]);
    @(posedge mclk);
    for (int i = 0; i < q.size(); i++)
      host.send(q[i]);
    host.rest();
  endtask

  // Waits for a three byte reply and compares it.
  task automatic expect_reply(input logic [7:0] mid);
    int n;
    n = 0;
    while (host.reply.size() < 3 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100)
    begin
      err_count++;
      test_done();
    end
    chk(host.reply[0], CH_LT);
    chk(host.reply[1], mid);
    chk(host.reply[2], CH_CR);
    host.reply.delete();
  endtask

  // Default method: trigger bytes are data; fill the buffer, then drain it.
  task automatic t_fifo();
    int n;
    reset_dut(TRIG_LINE);
    net_ready <= 1'b0;
    n = 0;
    @(negedge mclk);
    while (rx_ready === 1'b1 && n < 16)
    begin
      send_q('{TRIG_CHAR_RESET});
      n++;
      @(negedge mclk);
    end
    chk(8'(n), 8'(FIFO_DEPTH + 1));
    @(posedge mclk);
    net_ready <= 1'b1;
    repeat (40) @(posedge mclk);
    chk(8'(netq.size()), 8'(n));
    foreach (netq[i])
      chk(netq[i], TRIG_CHAR_RESET);
    chk({7'h0, cmd_mode_q}, 8'h00);
    $display("Test fifo done");
  endtask

  // Slowly spaced trigger bytes pass as data; the line is ignored here.
  task automatic t_slow_chars();
    reset_dut(TRIG_CHAR);
    send_q('{cfg_char0});
    repeat (2 * GAP) @(posedge mclk);
    send_q('{cfg_char1});
    repeat (2 * GAP) @(posedge mclk);
    send_q('{cfg_char2});
    line_n <= 1'b0;
    repeat (HOLD + 5) @(posedge mclk);
    line_n <= 1'b1;
    repeat (30) @(posedge mclk);
    chk({7'h0, cmd_mode_q}, 8'h00);
    chk(8'(netq.size()), 8'h03);
    chk(netq[0], cfg_char0);
    chk(netq[2], cfg_char2);
    $display("Test slow chars done");
  endtask

  // A broken trigger run and the off method both pass bytes on as data.
  task automatic t_no_entry();
    reset_dut(TRIG_CHAR);
    send_q('{cfg_char0, cfg_char1, 8'h58});
    repeat (10) @(posedge mclk);
    chk({7'h0, cmd_mode_q}, 8'h00);
    chk(8'(netq.size()), 8'h03);
    chk(netq[1], cfg_char1);
    chk(netq[2], 8'h58);
    reset_dut(TRIG_OFF);
    line_n <= 1'b0;
    send_q('{cfg_char0, cfg_char1, cfg_char2});
    repeat (HOLD + 5) @(posedge mclk);
    line_n <= 1'b1;
    chk({7'h0, cmd_mode_q}, 8'h00);
    chk(8'(netq.size()), 8'h03);
    $display("Test no entry done");
  endtask

  // Fast trigger enters command mode; then probes, errors and restarts.
  task automatic t_char_entry();
    reset_dut(TRIG_CHAR);
    send_q('{cfg_char0, cfg_char1, cfg_char2});
    expect_reply(CH_OK);
    chk({7'h0, cmd_mode_q}, 8'h01);
    chk({7'h0, tcp_block_q}, 8'h01);
    chk({7'h0, udp_block_q}, 8'h01);
    chk(8'(n_close), 8'h01);
    chk(8'(netq.size()), 8'h00);
    slow <= 1'b1;
    send_q('{CH_CR});
    expect_reply(CH_OK);
    send_q('{CH_CR, CH_LF});
    expect_reply(CH_OK);
    repeat (20) @(posedge mclk);
    chk(8'(host.reply.size()), 8'h00);
    send_q('{8'h58, CH_CR});
    expect_reply(CH_ERR);
    send_q('{CMD_LEAD, CMD_WRITE, RESTART_OPCODE0, RESTART_OPCODE1, ARG_DROP, CH_CR});
    expect_reply(CH_OK);
    chk(8'(n_drop), 8'h01);
    send_q('{CMD_LEAD, CMD_WRITE, RESTART_OPCODE0, RESTART_OPCODE1, ARG_SAVE, CH_CR});
    expect_reply(CH_OK);
    chk(8'(n_save), 8'h01);
    chk(8'(n_drop), 8'h01);
    slow <= 1'b0;
    $display("Test char entry done");
  endtask

  // Short line pulse is ignored, a long one enters; idle time restarts.
  task automatic t_line_idle();
    int n;
    reset_dut(TRIG_LINE);
    line_n <= 1'b0;
    repeat (HOLD - 1) @(posedge mclk);
    line_n <= 1'b1;
    repeat (5) @(posedge mclk);
    chk({7'h0, cmd_mode_q}, 8'h00);
    line_n <= 1'b0;
    repeat (HOLD + 2) @(posedge mclk);
    chk({7'h0, cmd_mode_q}, 8'h01);
    line_n <= 1'b1;
    expect_reply(CH_OK);
    repeat (IDLE - 40) @(posedge mclk);
    chk(8'(n_drop), 8'h00);
    n = 0;
    while (n_drop == 0 && n < 80)
    begin
      @(posedge mclk);
      n++;
    end
    chk(8'(n_drop), 8'h01);
    chk(8'(n_save), 8'h00);
    $display("Test line idle done");
  endtask

  initial
  begin
    rst       = 1'b1;
    cfg_load  = 1'b0;
    cfg_mode  = TRIG_LINE;
    cfg_char0 = 8'h11;
    cfg_char1 = 8'h22;
    cfg_char2 = 8'h33;
    line_n    = 1'b1;
    net_ready = 1'b1;
    slow      = 1'b0;
    err_count = 0;
    n_tests   = 0;
    t_fifo();
    t_slow_chars();
    t_no_entry();
    t_char_entry();
    t_line_idle();
    test_done();
  end
endmodule
`default_nettype wire
